//--- core/ipdc_cfg_regs.sv
// configuration register bank of an isa plug-and-play controller
// assumes: one 40 mhz clock, ahb-lite single master, serial eeprom
`timescale 1ns/10ps
`default_nettype none
`include "ipdc_consts.svh"

module ipdc_cfg_regs #(
    parameter int SK_HALF_CYC = `IPDC_SK_HALF_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic eeprom_cs,
    output logic eeprom_sk,
    output logic eeprom_di,
    input wire logic eeprom_do,
    input wire logic isa_iord_n,
    input wire logic isa_iowr_n,
    input wire logic [2:0] cs_addr_hit,
    output logic io_chip_select_zero_n,
    output logic io_chip_select_one_n,
    output logic io_chip_select_two_n,
    input wire logic [1:0] dev_dma_req,
    output logic [7:0] isa_drq,
    output logic ext_irq_mode
);
    import ipdc_pkg::*;

    // ----------------------------------------
    // storage and pin synchronisers
    // ----------------------------------------
    ipdc_word_t cfg_q [`IPDC_SLOTS];
    ipdc_word_t w0;
    ipdc_word_t w1;
    logic [2:0] pin_in;
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    logic [2:0] s3_q;
    logic [2:0] pin_f_q;
    logic do_f;
    logic strobe;

    assign w0 = cfg_q[0];
    assign w1 = cfg_q[1];
    assign pin_in = {eeprom_do, isa_iowr_n, isa_iord_n};
    assign do_f = pin_f_q[2];
    assign strobe = !pin_f_q[0] || !pin_f_q[1];

    // a change counts only once stages two and three agree
    genvar gp;
    generate
        for (gp = 0; gp < 3; gp++) begin : g_sync
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    s1_q[gp] <= 1'(`IPDC_PIN_RST >> gp);
                    s2_q[gp] <= 1'(`IPDC_PIN_RST >> gp);
                    s3_q[gp] <= 1'(`IPDC_PIN_RST >> gp);
                    pin_f_q[gp] <= 1'(`IPDC_PIN_RST >> gp);
                end else begin
                    s1_q[gp] <= pin_in[gp];
                    s2_q[gp] <= s1_q[gp];
                    s3_q[gp] <= s2_q[gp];
                    if (s2_q[gp] == s3_q[gp]) begin
                        pin_f_q[gp] <= s2_q[gp];
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // power-on eeprom loader
    // ----------------------------------------
    ipdc_state_t st_q;
    ipdc_state_t st_d;
    logic [15:0] div_q;
    logic tick;
    logic [4:0] ld_idx_q;
    logic [4:0] bit_q;
    logic [7:0] cmd_sh_q;
    logic [15:0] sh_q;
    logic sk_q;
    logic cs_q;
    logic di_q;
    logic [5:0] ld_addr;
    logic [8:0] ld_cmd;
    logic last_bit;
    logic ld_we;
    logic ld_done;
    ipdc_word_t ld_word;

    assign tick = div_q == 16'(SK_HALF_CYC - 1);
    // slot 16 holds word 0x14, after the device-specific words
    assign ld_addr = (ld_idx_q == 5'd16) ? `IPDC_CKS_ADDR :
                     {2'h0, ld_idx_q[3:0]};
    assign ld_cmd = {`IPDC_RD_OP, ld_addr};
    assign last_bit = bit_q == (`IPDC_FRAME_BITS - 5'd1);
    assign ld_we = st_q == IPDC_ST_SHIFT && tick && sk_q && last_bit;
    assign ld_word = {sh_q[14:0], do_f};
    assign ld_done = st_q == IPDC_ST_DONE;

    always_comb begin
        st_d = st_q;
        case (st_q)
            IPDC_ST_GAP: begin
                if (tick) begin
                    st_d = IPDC_ST_SHIFT;
                end
            end
            IPDC_ST_SHIFT: begin
                if (ld_we) begin
                    st_d = (ld_idx_q == 5'd16) ? IPDC_ST_DONE : IPDC_ST_GAP;
                end
            end
            IPDC_ST_DONE: st_d = IPDC_ST_DONE;
            default: st_d = IPDC_ST_GAP;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= IPDC_ST_GAP;
            div_q <= 16'h0000;
        end else begin
            st_q <= st_d;
            div_q <= (tick || ld_done) ? 16'h0000 : div_q + 16'h0001;
        end
    end

    // shift frame: di changes on falling sk, do sampled there too
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ld_idx_q <= 5'h00;
            bit_q <= 5'h00;
            cmd_sh_q <= 8'h00;
            sh_q <= 16'h0000;
            sk_q <= 1'b0;
            cs_q <= 1'b0;
            di_q <= 1'b0;
        end else if (st_q == IPDC_ST_GAP && tick) begin
            cs_q <= 1'b1;
            di_q <= ld_cmd[8];
            cmd_sh_q <= ld_cmd[7:0];
            bit_q <= 5'h00;
        end else if (st_q == IPDC_ST_SHIFT && tick) begin
            sk_q <= !sk_q;
            if (sk_q) begin
                bit_q <= bit_q + 5'd1;
                di_q <= cmd_sh_q[7];
                cmd_sh_q <= {cmd_sh_q[6:0], 1'b0};
                if (bit_q >= `IPDC_DATA_FIRST) begin
                    sh_q <= ld_word;
                end
                if (last_bit) begin
                    cs_q <= 1'b0;
                    ld_idx_q <= ld_idx_q + 5'd1;
                end
            end
        end
    end

    // ----------------------------------------
    // ahb-lite slave
    // ----------------------------------------
    logic ahb_go;
    logic addr_ok;
    logic wr_pend_q;
    logic rd_pend_q;
    logic map_q;
    logic [5:0] idx_q;
    logic ahb_we;
    logic [31:0] rd_mux;
    logic [31:0] stat_w;
    logic [1:0] mode;
    logic dma_mode;
    logic ill_mode;
    logic [31:0] hrdata_q;
    logic hready_q;

    assign ahb_go = hsel && htrans[1] && hready;
    assign addr_ok = haddr[31:8] == 24'h000000;
    assign mode = w0[`IPDC_MODE_LSB +: 2];
    assign dma_mode = mode == `IPDC_MODE_DMA;
    assign ill_mode = mode[1];
    // protected until software sees bit 15 set; loader is exempt
    assign ahb_we = wr_pend_q && map_q && idx_q < 6'(`IPDC_DEV_WORDS)
                    && ld_done && w0[`IPDC_WP_BIT];
    assign stat_w = {8'h00,
                     cfg_q[16][15:8],
                     cfg_q[16][7:0],
                     4'h0,
                     w0[`IPDC_WP_BIT],
                     ld_done && mode == `IPDC_MODE_EXT,
                     ill_mode,
                     ld_done};
    assign rd_mux = !map_q ? 32'h00000000 :
                    idx_q < 6'(`IPDC_DEV_WORDS) ?
                        {16'h0000, cfg_q[idx_q[3:0]]} :
                    idx_q == `IPDC_IDX_CKS ? {16'h0000, cfg_q[16]} :
                    idx_q == `IPDC_IDX_STAT ? stat_w : 32'h00000000;

    // reads take one wait state so a preceding write is visible
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            map_q <= 1'b0;
            idx_q <= 6'h00;
            hready_q <= 1'b1;
            hrdata_q <= 32'h00000000;
        end else begin
            wr_pend_q <= ahb_go && hwrite;
            rd_pend_q <= ahb_go && !hwrite;
            hready_q <= !(ahb_go && !hwrite);
            if (ahb_go) begin
                idx_q <= haddr[7:2];
                map_q <= addr_ok;
            end
            if (rd_pend_q) begin
                hrdata_q <= rd_mux;
            end
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hready_q;
    assign hresp = 1'b0;

    genvar gw;
    generate
        for (gw = 0; gw < `IPDC_SLOTS; gw++) begin : g_word
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cfg_q[gw] <= `IPDC_WORD_RST;
                end else if (ld_we && ld_idx_q == 5'(gw)) begin
                    cfg_q[gw] <= ld_word;
                end else if (ahb_we && idx_q == 6'(gw)) begin
                    cfg_q[gw] <= hwdata[15:0];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // chip selects and dma routing
    // ----------------------------------------
    logic [2:0] cs_raw;
    logic [2:0] cs_act;
    logic [7:0] drq_d;
    logic [2:0] code0;
    logic [2:0] code1;
    logic [2:0] csn_q;
    logic [7:0] drq_q;
    logic ext_q;

    assign code0 = w1[`IPDC_DRQ0_LSB +: 3];
    assign code1 = w1[`IPDC_DRQ1_LSB +: 3];

    genvar gc;
    generate
        for (gc = 0; gc < 3; gc++) begin : g_cs
            assign cs_raw[gc] = ld_done && cs_addr_hit[gc]
                                && (w0[gc] || strobe);
        end
    endgenerate

    // wired-and of active-low pins: either asserting pulls both low
    assign cs_act[0] = cs_raw[0] || (w0[`IPDC_WAND1_BIT] && cs_raw[1])
                       || (w0[`IPDC_WAND2_BIT] && cs_raw[2]);
    assign cs_act[1] = cs_raw[1]
                       || (w0[`IPDC_WAND1_BIT] && cs_raw[0]);
    assign cs_act[2] = cs_raw[2]
                       || (w0[`IPDC_WAND2_BIT] && cs_raw[0]);

    genvar gd;
    generate
        for (gd = 0; gd < 8; gd++) begin : g_drq
            // code 100 selects no channel, so line 4 never drives
            assign drq_d[gd] = ld_done && dma_mode
                && 3'(gd) != `IPDC_DRQ_NONE
                && ((dev_dma_req[1] && code1 == 3'(gd))
                || (dev_dma_req[0] && code0 == 3'(gd)));
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            csn_q <= 3'h7;
            drq_q <= 8'h00;
            ext_q <= 1'b0;
        end else begin
            csn_q <= ~cs_act;
            drq_q <= drq_d;
            ext_q <= ld_done && mode == `IPDC_MODE_EXT;
        end
    end

    assign io_chip_select_zero_n = csn_q[0];
    assign io_chip_select_one_n = csn_q[1];
    assign io_chip_select_two_n = csn_q[2];
    assign isa_drq = drq_q;
    assign ext_irq_mode = ext_q;
    assign eeprom_cs = cs_q;
    assign eeprom_sk = sk_q;
    assign eeprom_di = di_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    load_frame_a: assert property (
        $rose(cs_q) |-> !ld_done && ld_idx_q <= 5'd16)
        else $error("eeprom frame outside power-on load");
    load_store_a: assert property (
        ld_we && ld_idx_q == 5'd0 |=> w0 == $past(ld_word))
        else $error("loaded word zero not stored");
    mode_follow_a: assert property (
        ld_done && mode == `IPDC_MODE_EXT |=> ext_irq_mode)
        else $error("extended mode not taken from word zero");
    wp_hold_a: assert property (
        wr_pend_q && !w0[`IPDC_WP_BIT] |=> $stable(w0) && $stable(w1))
        else $error("write went through while protected");
    cs_wand2_a: assert property (
        !io_chip_select_two_n && $past(w0[`IPDC_WAND2_BIT])
        |-> !io_chip_select_zero_n)
        else $error("select two not wire-anded with zero");
    cs_wand1_a: assert property (
        !io_chip_select_one_n && $past(w0[`IPDC_WAND1_BIT])
        |-> !io_chip_select_zero_n)
        else $error("select one not wire-anded with zero");
    mode_drq_a: assert property (
        !dma_mode |=> isa_drq == 8'h00)
        else $error("dma request driven outside dma mode");
    cs_qual_a: assert property (
        $fell(io_chip_select_one_n) && !$past(w0[`IPDC_WAND1_BIT])
        |-> $past(cs_addr_hit[1]) && ($past(w0[1]) || $past(strobe)))
        else $error("select one asserted without qualification");
    drq_one_a: assert property (
        ld_done && dma_mode && dev_dma_req[1]
        && code1 != `IPDC_DRQ_NONE |=> isa_drq[$past(code1)])
        else $error("dma request one not routed");
    drq_zero_a: assert property (
        ld_done && dma_mode && dev_dma_req[0]
        && code0 != `IPDC_DRQ_NONE |=> isa_drq[$past(code0)])
        else $error("dma request zero not routed");

    load_done_c: cover property ($rose(ld_done));
    wand_c: cover property (!io_chip_select_two_n && w0[14]);
    drq_c: cover property (isa_drq != 8'h00);

endmodule
`default_nettype wire

//--- core/ipdc_consts.svh
// constants of the isa pnp dma/io configuration block
// assumes: included by bare name from core/
`ifndef IPDC_CONSTS_SVH
`define IPDC_CONSTS_SVH

// register indices (byte address is four times the index)
`define IPDC_IDX_IOQ 6'h00
`define IPDC_IDX_DMA 6'h01
`define IPDC_IDX_CKS 6'h14
`define IPDC_IDX_STAT 6'h20
`define IPDC_DEV_WORDS 16
`define IPDC_SLOTS 17

// decode qualification fields
`define IPDC_WP_BIT 15
`define IPDC_WAND2_BIT 14
`define IPDC_WAND1_BIT 13
`define IPDC_MODE_LSB 8
`define IPDC_MODE_DMA 2'h0
`define IPDC_MODE_EXT 2'h1

// dma routing fields
`define IPDC_DRQ1_LSB 5
`define IPDC_DRQ0_LSB 0
`define IPDC_DRQ_NONE 3'h4

// status fields
`define IPDC_ST_DONE 0
`define IPDC_ST_ILL 1
`define IPDC_ST_EXT 2
`define IPDC_ST_WEN 3
`define IPDC_ST_CKS_LSB 8
`define IPDC_ST_RES_LSB 16

// reset values
`define IPDC_WORD_RST 16'h0000
`define IPDC_PIN_RST 3'h3

// serial eeprom read frame: start, opcode, 6 address bits
`define IPDC_RD_OP 3'h6
`define IPDC_CKS_ADDR 6'h14
`define IPDC_FRAME_BITS 5'd25
`define IPDC_DATA_FIRST 5'd9

// timing
`define IPDC_CLK_NS 25
`define IPDC_SK_HALF_NS 1000
`define IPDC_SK_HALF_CYC \
    ((`IPDC_SK_HALF_NS + `IPDC_CLK_NS - 1) / `IPDC_CLK_NS)

`endif

//--- core/ipdc_pkg.sv
// types of the isa pnp dma/io configuration block
// assumes: compiled before ipdc_cfg_regs
package ipdc_pkg;

    typedef logic [15:0] ipdc_word_t;

    typedef enum logic [2:0] {
        IPDC_ST_GAP = 3'b001,
        IPDC_ST_SHIFT = 3'b010,
        IPDC_ST_DONE = 3'b100
    } ipdc_state_t;

endpackage

//--- tb/ipdc_eeprom_model.sv
// serial configuration eeprom answering microwire-style read frames
// assumes: tb fills mem before the design leaves reset
`timescale 1ns/10ps
`default_nettype none

module ipdc_eeprom_model (
    input wire logic eeprom_cs,
    input wire logic eeprom_sk,
    input wire logic eeprom_di,
    output logic eeprom_do
);
    logic [15:0] mem [0:63];
    logic [5:0] adr;
    logic [2:0] op;
    int n = 0;
    int frames = 0;
    int errs = 0;

    initial eeprom_do = 1'b0;

    // released line shows the inverse, so a stale bit cannot pass
    always @(negedge eeprom_cs) begin
        eeprom_do = ~eeprom_do;
        if (n == 25) begin
            if (adr !== ((frames < 16) ? frames[5:0] : 6'h14)) errs++;
            frames++;
        end else if (n != 0) begin
            errs++;
        end
        n = 0;
    end

    always @(posedge eeprom_sk) begin
        if (eeprom_cs) begin
            if (n < 3) op = {op[1:0], eeprom_di};
            if (n == 3 && op !== 3'h6) errs++;
            if (n >= 3 && n <= 8) adr = {adr[4:0], eeprom_di};
            if (n == 8) eeprom_do = 1'b0;
            else if (n >= 9 && n <= 24) eeprom_do = mem[adr][24 - n];
            n++;
        end
    end
endmodule
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the isa pnp configuration register bank
// assumes: design from core/, eeprom model from tb/
`timescale 1ns/10ps
`default_nettype none

module tb;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans, rq, w, dev_dma_req;
    logic [2:0] hsize, cs_addr_hit, c1, c0, q, raw, xn;
    logic eeprom_cs, eeprom_sk, eeprom_di, eeprom_do, s;
    logic isa_iord_n, isa_iowr_n, ext_irq_mode, x0, x1, x2;
    logic io_chip_select_zero_n, io_chip_select_one_n;
    logic io_chip_select_two_n;
    logic [7:0] isa_drq, e;
    int n_mismatch = 0;
    int tests_run = 0;
    int i, h, k;

    assign hready = hreadyout;

    // half period must exceed the four-cycle lag of the eeprom_do sync
    ipdc_cfg_regs #(.SK_HALF_CYC(8)) ipdc_cfg_regs_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .eeprom_cs(eeprom_cs),
        .eeprom_sk(eeprom_sk), .eeprom_di(eeprom_di),
        .eeprom_do(eeprom_do), .isa_iord_n(isa_iord_n),
        .isa_iowr_n(isa_iowr_n), .cs_addr_hit(cs_addr_hit),
        .io_chip_select_zero_n(io_chip_select_zero_n),
        .io_chip_select_one_n(io_chip_select_one_n),
        .io_chip_select_two_n(io_chip_select_two_n),
        .dev_dma_req(dev_dma_req), .isa_drq(isa_drq),
        .ext_irq_mode(ext_irq_mode)
    );

    ipdc_eeprom_model ipdc_eeprom_model_inst (
        .eeprom_cs(eeprom_cs), .eeprom_sk(eeprom_sk),
        .eeprom_di(eeprom_di), .eeprom_do(eeprom_do)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask

    task automatic close_out;
        $display("mismatches=%0d checks=%0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic wait_rdy;
        int t;
        t = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            if (++t > 20) begin
                n_mismatch++;
                close_out;
            end
            @(posedge hclk);
        end
    endtask

    // one single word transfer, entered just after a rising edge
    task automatic ahb(input logic wr, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        rd = hrdata;
        chk(hresp, 32'h0);
    endtask

    task automatic wrw(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        ahb(1'b1, a, d, dummy);
    endtask

    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] got;
        ahb(1'b0, a, 32'h0, got);
        chk(got, exp);
    endtask

    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    initial begin
        #1000000;
        n_mismatch++;
        close_out;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        isa_iord_n = 1'b1;
        isa_iowr_n = 1'b1;
        cs_addr_hit = 3'h0;
        dev_dma_req = 2'h0;
        for (i = 0; i < 64; i++)
            ipdc_eeprom_model_inst.mem[i] = 16'h1100 + i[15:0];
        ipdc_eeprom_model_inst.mem[0] = 16'h8000; // reserved bits zero
        ipdc_eeprom_model_inst.mem[1] = 16'h00a2;
        ipdc_eeprom_model_inst.mem[20] = 16'h3c5a;
        repeat (3) @(posedge hclk);
        chk({io_chip_select_two_n, io_chip_select_one_n,
             io_chip_select_zero_n, ext_irq_mode, isa_drq}, 32'he00);
        hresetn <= 1'b1;
        rdc(32'h0, 32'h0);
        wrw(32'h04, 32'hffff);
        k = 0;
        do begin
            ahb(1'b0, 32'h80, 32'h0, r);
            k++;
        end while (r[0] !== 1'b1 && k < 4000);
        if (r[0] !== 1'b1) begin
            n_mismatch++;
            close_out;
        end
        chk(ipdc_eeprom_model_inst.frames, 17);
        chk(ipdc_eeprom_model_inst.errs, 0);
        for (i = 0; i < 16; i++)
            rdc(i * 4, {16'h0, ipdc_eeprom_model_inst.mem[i]});
        rdc(32'h50, 32'h3c5a);
        rdc(32'h80, 32'h003c5a09);
        wrw(32'h50, 32'h1234);
        rdc(32'h50, 32'h3c5a);
        wrw(32'h44, 32'h55);
        rdc(32'h44, 32'h0);
        wrw(32'h08, 32'hffffa5a5);
        rdc(32'h08, 32'h0000a5a5);
        for (i = 0; i < 8; i++) begin
            c1 = i[2:0];
            c0 = 3'h7 - c1;
            rq = (i < 4) ? 2'h3 : {i[0], ~i[0]};
            dev_dma_req <= rq;
            wrw(32'h04, {24'h0, c1, 2'h0, c0});
            repeat (3) @(posedge hclk);
            e = 8'h00;
            if (c1 != 3'h4) e[c1] = rq[1];
            if (c0 != 3'h4) e[c0] = e[c0] | rq[0];
            chk(isa_drq, e);
        end
        for (i = 0; i < 4; i++) begin
            wrw(32'h0, 32'h8000 | (i << 8));
            repeat (3) @(posedge hclk);
            chk({ext_irq_mode, isa_drq}, {i == 1, (i == 0) ? e : 8'h00});
            rdc(32'h80, 32'h003c5a09 | ((i == 1) ? 4 : 0) | ((i > 1) ? 2 : 0));
        end
        for (i = 0; i < 64; i++) begin
            q = i[2:0];
            w = i[4:3];
            s = i[5];
            isa_iord_n <= ~(s & i[0]);
            isa_iowr_n <= ~(s & ~i[0]);
            wrw(32'h0, {16'h0, 1'b1, w, 10'h0, q});
            repeat (6) @(posedge hclk);
            for (h = 0; h < 8; h++) begin
                cs_addr_hit <= h[2:0];
                repeat (2) @(posedge hclk);
                raw = h[2:0] & (q | {3{s}});
                x0 = raw[0] | (w[0] & raw[1]) | (w[1] & raw[2]);
                x1 = raw[1] | (w[0] & raw[0]);
                x2 = raw[2] | (w[1] & raw[0]);
                xn = ~{x2, x1, x0};
                chk({io_chip_select_two_n, io_chip_select_one_n,
                     io_chip_select_zero_n}, xn);
            end
        end
        // protection last: once set, no bus write can clear it again
        wrw(32'h0, 32'h7);
        wrw(32'h04, 32'h0011);
        rdc(32'h04, {24'h0, c1, 2'h0, c0});
        wrw(32'h0, 32'h8000);
        rdc(32'h0, 32'h7);
        rdc(32'h80, 32'h003c5a01);
        close_out;
    end
endmodule
`default_nettype wire
